// >>> hw/lvpecl_channel_divider_pair.sv
/*
 * Two programmable channel dividers feeding the two LVPECL output pairs,
 * with an APB register file, bypass, sync hold, forced level, start level,
 * phase offset and a direct-to-output path from oscillator or external clock.
 * Assumes: divider input, oscillator, external clock and chip sync arrive as
 * pins sampled by pclk (so they must run well below pclk/2); the distribution
 * source selector comes from logic on pclk.
 */
// Register access over APB was chosen for this implementation.
// Notes on behaviour
// RULE1: low time is low field plus one
// RULE2: high time is high field plus one
// RULE3: bypass passes input clock straight through
// RULE4: first divider resets with bypass set
// RULE5: second divider resets with bypass clear
// RULE6: ignore-sync bit decides whether sync is obeyed
// RULE7: force bit gives static level; needs ignore-sync
// RULE8: start bit picks starting output level
// RULE9: four-bit phase offset delays the start
// RULE10: direct bit clear feeds pair from divider
// RULE11: direct bit routes oscillator or external clock
// RULE12: duty correction bit disables correction when set
// RULE13: second divider has own count register
// RULE14: second divider has start bit and phase
// RULE15: second divider has own routing register
// RULE16: period is low plus high plus two
`timescale 1ns/1ns

// ==========================================================
// one divider channel
module clock_divider_channel
	import lvpecl_div_pkg::*;
#(
	parameter int unsigned COUNT_W = CNT_W
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               in_level,
	input  wire logic               in_rise,
	input  wire logic               sync_active,
	input  wire logic [COUNT_W-1:0] low_count,
	input  wire logic [COUNT_W-1:0] high_count,
	input  wire logic               bypass,
	input  wire logic               ignore_sync,
	input  wire logic               force_level,
	input  wire logic               start_high,
	input  wire logic [COUNT_W-1:0] phase_offset,
	output logic                    div_out,
	output logic                    running
);

	// the counters cannot shrink to nothing
	if (COUNT_W < 1) begin : g_bad_width
		$error("COUNT_W must be at least 1");
	end

	div_state_t         state_ff;
	div_state_t         nxt_state;
	logic [COUNT_W-1:0] cnt_ff;
	logic [COUNT_W-1:0] nxt_cnt;
	logic [COUNT_W-1:0] phase_ff;
	logic [COUNT_W-1:0] nxt_phase;
	logic               level_ff;
	logic               nxt_level;
	logic               out_ff;
	logic               nxt_out;
	logic               held;

	// held while bypassed or while an obeyed sync is asserted
	assign held = bypass | (sync_active & ~ignore_sync); // see RULE3 see RULE6

	// counting: phase wait first, then alternate low and high spans
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_phase = phase_ff;
		nxt_level = level_ff;
		unique case (state_ff)
			DIV_HOLD: begin
				nxt_cnt   = '0;
				nxt_phase = phase_offset; // see RULE9
				nxt_level = start_high; // see RULE8
				if (!held) begin
					nxt_state = (phase_offset == '0) ? DIV_RUN : DIV_PHASE_WAIT;
				end
			end
			DIV_PHASE_WAIT: begin
				// each offset step costs one input cycle before the first span
				if (in_rise) begin
					nxt_phase = phase_ff - 1'b1; // see RULE9
					if (phase_ff == {{(COUNT_W-1){1'b0}}, 1'b1}) begin
						nxt_state = DIV_RUN;
					end
				end
			end
			DIV_RUN: begin
				// span of field+1 input cycles, so period is low+high+2
				if (in_rise) begin
					if (cnt_ff == (level_ff ? high_count : low_count)) begin // see RULE1 see RULE2
						nxt_level = ~level_ff; // see RULE16
						nxt_cnt   = '0;
					end else begin
						nxt_cnt = cnt_ff + 1'b1;
					end
				end
			end
			default: nxt_state = DIV_HOLD;
		endcase
		if (held) begin
			nxt_state = DIV_HOLD;
		end
	end

	// divider state and output flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= DIV_HOLD;
			cnt_ff   <= '0;
			phase_ff <= '0;
			level_ff <= 1'b0;
			out_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			phase_ff <= nxt_phase;
			level_ff <= nxt_level;
			out_ff   <= nxt_out; // registered so the pin never glitches on a select change
		end
	end

	// output select: bypass wins, then forced level during an ignored sync, else divider
	always_comb begin
		if (bypass) begin
			nxt_out = in_level; // see RULE3
		end else if (ignore_sync && sync_active) begin
			nxt_out = force_level; // see RULE7
		end else if (state_ff == DIV_RUN) begin
			nxt_out = nxt_level;
		end else begin
			nxt_out = start_high; // see RULE8
		end
	end

	assign div_out = out_ff;
	assign running = (state_ff == DIV_RUN);

endmodule

// ==========================================================
// top: register file, synchronisers, two channels, output routing
module lvpecl_channel_divider_pair
	import lvpecl_div_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0]      prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              dist_clk_in,
	input  wire logic              osc_clk_in,
	input  wire logic              ext_clk_in,
	input  wire logic              chip_sync_n,
	input  wire logic [1:0]        dist_source_sel,
	output logic                   first_pair_output_a,
	output logic                   first_pair_output_b,
	output logic                   second_pair_output_a,
	output logic                   second_pair_output_b,
	output logic                   first_pair_duty_correct_disable,
	output logic                   second_pair_duty_correct_disable
);

	// ==========================================================
	// registers
	logic [REG_W-1:0]  cyc0_ff;
	logic [REG_W-1:0]  ctl0_ff;
	logic [REG_W-1:0]  route0_ff;
	logic [REG_W-1:0]  cyc1_ff;
	logic [REG_W-1:0]  ctl1_ff;
	logic [REG_W-1:0]  route1_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic              pslverr_ff;
	logic [DATA_W-1:0] nxt_prdata;
	logic              nxt_pslverr;
	logic [IDX_W-1:0]  idx;
	logic              aligned;
	logic              wr_commit;

	// pin synchronisers: stage one is read only by stage two
	logic [3:0]        sync1_ff;
	logic [3:0]        sync2_ff;
	logic              dist_prev_ff;
	logic              dist_rise;
	logic              sync_active;

	// channel results
	logic              div0_out;
	logic              div1_out;
	logic              div0_run;
	logic              div1_run;
	logic              direct_src;
	logic              direct_ok;
	logic              nxt_pair0;
	logic              nxt_pair1;
	logic              pair0_ff;
	logic              pair1_ff;

	// ==========================================================
	// APB decode
	assign idx       = paddr[ADDR_W-1:2];
	assign aligned   = (paddr[1:0] == 2'h0);
	assign wr_commit = psel & penable & pwrite;

	// read data and error are latched in setup, so access needs no wait state
	always_comb begin
		nxt_prdata  = '0;
		nxt_pslverr = 1'b0;
		if (!aligned) begin
			nxt_pslverr = 1'b1;
		end else begin
			unique case (idx)
				IDX_DIV0_CYCLE_COUNTS:   nxt_prdata[REG_W-1:0] = cyc0_ff;
				IDX_DIV0_CONTROL:        nxt_prdata[REG_W-1:0] = ctl0_ff;
				IDX_DIV0_OUTPUT_ROUTING: nxt_prdata[REG_W-1:0] = route0_ff;
				IDX_DIV1_CYCLE_COUNTS:   nxt_prdata[REG_W-1:0] = cyc1_ff;
				IDX_DIV1_CONTROL:        nxt_prdata[REG_W-1:0] = ctl1_ff;
				IDX_DIV1_OUTPUT_ROUTING: nxt_prdata[REG_W-1:0] = route1_ff;
				IDX_DIVIDER_STATUS: begin
					// read-only view of live divider state; writes are refused
					nxt_prdata[5:0] = {dist_source_sel, div1_run, div0_run, div1_out, div0_out};
					nxt_pslverr     = pwrite;
				end
				default: nxt_pslverr = 1'b1;
			endcase
		end
	end

	// answer latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end else if (psel && !penable) begin
			prdata_ff  <= pwrite ? '0 : nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = pslverr_ff & psel & penable;

	// register writes land at the access edge; erroring writes change nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc0_ff   <= RST_CYCLE_COUNTS;
			ctl0_ff   <= RST_DIV0_CONTROL; // see RULE4
			route0_ff <= RST_ROUTING; // see RULE10 see RULE12
			cyc1_ff   <= RST_CYCLE_COUNTS; // see RULE13
			ctl1_ff   <= RST_DIV1_CONTROL; // see RULE5 see RULE14
			route1_ff <= RST_ROUTING; // see RULE15
		end else if (wr_commit && aligned) begin
			unique case (idx)
				IDX_DIV0_CYCLE_COUNTS:   cyc0_ff   <= pwdata[REG_W-1:0];
				IDX_DIV0_CONTROL:        ctl0_ff   <= pwdata[REG_W-1:0];
				IDX_DIV0_OUTPUT_ROUTING: route0_ff <= pwdata[REG_W-1:0] & ROUTE_MASK;
				IDX_DIV1_CYCLE_COUNTS:   cyc1_ff   <= pwdata[REG_W-1:0]; // see RULE13
				IDX_DIV1_CONTROL:        ctl1_ff   <= pwdata[REG_W-1:0]; // see RULE14
				IDX_DIV1_OUTPUT_ROUTING: route1_ff <= pwdata[REG_W-1:0] & ROUTE_MASK;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// pin synchronisers, two flops each
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff     <= 4'h8;
			sync2_ff     <= 4'h8;
			dist_prev_ff <= 1'b0;
		end else begin
			sync1_ff     <= {chip_sync_n, ext_clk_in, osc_clk_in, dist_clk_in};
			sync2_ff     <= sync1_ff;
			dist_prev_ff <= sync2_ff[0]; // resets to the idle level, so no false edge
		end
	end

	// rising edges of the divider input are the counted input cycles
	assign dist_rise   = sync2_ff[0] & ~dist_prev_ff;
	assign sync_active = ~sync2_ff[3];

	// ==========================================================
	// the two channels, identical logic with their own fields
	clock_divider_channel #(.COUNT_W (CNT_W)) u_div0 (
		.pclk         (pclk),
		.presetn      (presetn),
		.in_level     (sync2_ff[0]),
		.in_rise      (dist_rise),
		.sync_active  (sync_active),
		.low_count    (cyc0_ff[LOW_CNT_LSB +: CNT_W]), // see RULE1
		.high_count   (cyc0_ff[HIGH_CNT_LSB +: CNT_W]), // see RULE2
		.bypass       (ctl0_ff[CTL_BYPASS_BIT]),
		.ignore_sync  (ctl0_ff[CTL_NOSYNC_BIT]),
		.force_level  (ctl0_ff[CTL_FORCE_BIT]),
		.start_high   (ctl0_ff[CTL_START_BIT]),
		.phase_offset (ctl0_ff[CTL_PHASE_LSB +: CNT_W]),
		.div_out      (div0_out),
		.running      (div0_run)
	);

	clock_divider_channel #(.COUNT_W (CNT_W)) u_div1 (
		.pclk         (pclk),
		.presetn      (presetn),
		.in_level     (sync2_ff[0]),
		.in_rise      (dist_rise),
		.sync_active  (sync_active),
		.low_count    (cyc1_ff[LOW_CNT_LSB +: CNT_W]), // see RULE13
		.high_count   (cyc1_ff[HIGH_CNT_LSB +: CNT_W]), // see RULE13
		.bypass       (ctl1_ff[CTL_BYPASS_BIT]),
		.ignore_sync  (ctl1_ff[CTL_NOSYNC_BIT]),
		.force_level  (ctl1_ff[CTL_FORCE_BIT]),
		.start_high   (ctl1_ff[CTL_START_BIT]), // see RULE14
		.phase_offset (ctl1_ff[CTL_PHASE_LSB +: CNT_W]), // see RULE14
		.div_out      (div1_out),
		.running      (div1_run)
	);

	// ==========================================================
	// direct-to-output routing; selector 01b or 11b keeps the divider path
	assign direct_ok  = (dist_source_sel == SRC_OSC) || (dist_source_sel == SRC_EXT_CLK);
	assign direct_src = (dist_source_sel == SRC_OSC) ? sync2_ff[1] : sync2_ff[2]; // see RULE11

	always_comb begin
		nxt_pair0 = div0_out; // see RULE10
		nxt_pair1 = div1_out;
		if (route0_ff[ROUTE_DIRECT_BIT] && direct_ok) begin
			nxt_pair0 = direct_src; // see RULE11
		end
		if (route1_ff[ROUTE_DIRECT_BIT] && direct_ok) begin
			nxt_pair1 = direct_src; // see RULE15
		end
	end

	// both pins of a pair share one flop, so they never skew apart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair0_ff <= 1'b0;
			pair1_ff <= 1'b0;
		end else begin
			pair0_ff <= nxt_pair0;
			pair1_ff <= nxt_pair1;
		end
	end

	assign first_pair_output_a  = pair0_ff;
	assign first_pair_output_b  = pair0_ff;
	assign second_pair_output_a = pair1_ff;
	assign second_pair_output_b = pair1_ff;

	// correction itself is analog in the driver; only the control level leaves here
	assign first_pair_duty_correct_disable  = route0_ff[ROUTE_DCC_BIT]; // see RULE12
	assign second_pair_duty_correct_disable = route1_ff[ROUTE_DCC_BIT]; // see RULE15

endmodule

// >>> shared/lvpecl_div_pkg.sv
/*
 * Shared constants for the two LVPECL-pair channel dividers: register
 * indices, field positions, reset values and the states of a divider.
 * Assumes a 32-bit APB slave where each register index sits at byte address 4*index.
 */
package lvpecl_div_pkg;

	// ==========================================================
	// bus geometry
	localparam int unsigned ADDR_W   = 11;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned IDX_W    = 9;
	localparam int unsigned REG_W    = 8;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [IDX_W-1:0] IDX_DIV0_CYCLE_COUNTS   = 9'h190;
	localparam logic [IDX_W-1:0] IDX_DIV0_CONTROL        = 9'h191;
	localparam logic [IDX_W-1:0] IDX_DIV0_OUTPUT_ROUTING = 9'h192;
	localparam logic [IDX_W-1:0] IDX_DIV1_CYCLE_COUNTS   = 9'h196;
	localparam logic [IDX_W-1:0] IDX_DIV1_CONTROL        = 9'h197;
	localparam logic [IDX_W-1:0] IDX_DIV1_OUTPUT_ROUTING = 9'h198;
	localparam logic [IDX_W-1:0] IDX_DIVIDER_STATUS      = 9'h1a0;

	// ==========================================================
	// field positions
	localparam int unsigned LOW_CNT_LSB     = 4;
	localparam int unsigned HIGH_CNT_LSB    = 0;
	localparam int unsigned CNT_W           = 4;
	localparam int unsigned CTL_BYPASS_BIT  = 7;
	localparam int unsigned CTL_NOSYNC_BIT  = 6;
	localparam int unsigned CTL_FORCE_BIT   = 5;
	localparam int unsigned CTL_START_BIT   = 4;
	localparam int unsigned CTL_PHASE_LSB   = 0;
	localparam int unsigned ROUTE_DIRECT_BIT = 1;
	localparam int unsigned ROUTE_DCC_BIT    = 0;
	localparam logic [REG_W-1:0] ROUTE_MASK  = 8'h03;

	// ==========================================================
	// reset values
	localparam logic [REG_W-1:0] RST_CYCLE_COUNTS = 8'h00;
	localparam logic [REG_W-1:0] RST_DIV0_CONTROL = 8'h80;
	localparam logic [REG_W-1:0] RST_DIV1_CONTROL = 8'h00;
	localparam logic [REG_W-1:0] RST_ROUTING      = 8'h00;

	// ==========================================================
	// distribution source selector codes
	localparam logic [1:0] SRC_EXT_CLK = 2'h0;
	localparam logic [1:0] SRC_NO_EFFECT = 2'h1;
	localparam logic [1:0] SRC_OSC     = 2'h2;

	// ==========================================================
	// divider states
	typedef enum logic [1:0] {
		DIV_HOLD       = 2'b00,
		DIV_PHASE_WAIT = 2'b01,
		DIV_RUN        = 2'b10
	} div_state_t;

endpackage

// >>> sim/div_pair_props.sv
/* Port checker for the channel divider pair: APB answers, pair symmetry,
 * bypass, direct path and duty level. Assumes package and top compiled first. */
`timescale 1ns/1ns
module div_pair_props
	import lvpecl_div_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              dist_clk_in,
	input wire logic              osc_clk_in,
	input wire logic [1:0]        dist_source_sel,
	input wire logic              first_pair_output_a,
	input wire logic              first_pair_output_b,
	input wire logic              second_pair_output_a,
	input wire logic              second_pair_output_b,
	input wire logic              first_pair_duty_correct_disable
);
	logic       wr_ok;
	logic       byp0_ff;
	logic       dir0_ff;
	logic       dcc0_ff;
	logic [2:0] settle_ff;

	assign wr_ok = psel && penable && pwrite && pready;

	// shadow of the bits steering the first pair, same reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byp0_ff <= 1'h1;
			dir0_ff <= 1'h0;
			dcc0_ff <= 1'h0;
		end else if (wr_ok && paddr == {IDX_DIV0_CONTROL, 2'h0}) begin
			byp0_ff <= pwdata[CTL_BYPASS_BIT];
		end else if (wr_ok && paddr == {IDX_DIV0_OUTPUT_ROUTING, 2'h0}) begin
			dir0_ff <= pwdata[ROUTE_DIRECT_BIT];
			dcc0_ff <= pwdata[ROUTE_DCC_BIT];
		end
	end

	// cycles since reset or a write; the sync pipe needs four to refill
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_ff <= 3'h0;
		end else if (wr_ok) begin
			settle_ff <= 3'h0;
		end else if (settle_ff != 3'h7) begin
			settle_ff <= settle_ff + 3'h1;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// properties
	sequence s_access;
		psel && penable;
	endsequence

	sequence s_settled;
		settle_ff > 3'h3;
	endsequence

	a_ready_always: assert property (pready)
		else $error("pready low");
	a_pair0_equal: assert property (first_pair_output_a == first_pair_output_b)
		else $error("first pair split");
	a_pair1_equal: assert property (second_pair_output_a == second_pair_output_b)
		else $error("second pair split");
	a_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	a_misaligned_err: assert property (s_access ##0 paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned not refused");
	a_read_upper_zero: assert property (s_access ##0 !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read upper bits set");
	a_bypass_follow: assert property (s_settled ##0 byp0_ff && !dir0_ff
		|-> first_pair_output_a == $past(dist_clk_in, 4)) else $error("bypass not passing");
	a_direct_osc: assert property (s_settled ##0 dir0_ff && $past(dist_source_sel) == SRC_OSC
		|-> first_pair_output_a == $past(osc_clk_in, 3)) else $error("oscillator not routed");
	a_dcc_level: assert property (first_pair_duty_correct_disable == dcc0_ff)
		else $error("duty level wrong");
endmodule

bind lvpecl_channel_divider_pair div_pair_props chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .dist_clk_in, .osc_clk_in, .dist_source_sel, .first_pair_output_a,
	.first_pair_output_b, .second_pair_output_a, .second_pair_output_b,
	.first_pair_duty_correct_disable
);

// >>> sim/tb.sv
/* Self-checking bench for the channel divider pair over APB.
 * Assumes package, design and checker are compiled before it. */
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
$display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end
module tb
	import lvpecl_div_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic              dist_clk_in, osc_clk_in, ext_clk_in, chip_sync_n;
	logic [1:0]        dist_source_sel;
	logic              fa, fb, sa, sb, fdcc, sdcc;
	logic [7:0]        cnt_ff;
	int                fail_count, compares, n, hi, lo, d0;
	logic [7:0]        spans [3] = '{8'h21, 8'h00, 8'hfe};
	logic [7:0]        ctl_v [4] = '{8'h10, 8'h00, 8'h60, 8'h40};
	int                togs [4] = '{8, 4, 16, 4};

	lvpecl_channel_divider_pair uut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .dist_clk_in, .osc_clk_in, .ext_clk_in, .chip_sync_n, .dist_source_sel,
		.first_pair_output_a(fa), .first_pair_output_b(fb), .second_pair_output_a(sa),
		.second_pair_output_b(sb), .first_pair_duty_correct_disable(fdcc),
		.second_pair_duty_correct_disable(sdcc)
	);

	// 125 MHz bus clock
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end

	// pin clocks well below pclk/2: divider input /4, oscillator /8, external /16
	always @(posedge pclk) begin
		cnt_ff <= cnt_ff + 8'h01;
		dist_clk_in <= cnt_ff[1];
		osc_clk_in <= cnt_ff[2];
		ext_clk_in <= cnt_ff[3];
	end

	task automatic wrap_up;
		if (fail_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// one APB transfer; an idle edge follows so the next setup never collides
	task automatic apb(input logic w, input logic [10:0] a, input logic [7:0] d);
		int k;
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
		if (k >= 50) begin
			fail_count++;
			wrap_up();
		end
		@(posedge pclk);
	endtask

	task automatic rchk(input logic [10:0] a, input logic [7:0] e);
		apb(1'h0, a, 8'h00);
		`CHK(rd, {24'h0, e})
		`CHK(err, 1'h0)
	endtask

	// cycles until a pair shows level v; bounded
	task automatic till(input bit ch, input logic v, output int c);
		c = 0;
		while ((ch ? sa : fa) !== v && c < 400) begin
			@(posedge pclk);
			c++;
		end
		if (c >= 400) begin
			fail_count++;
			wrap_up();
		end
	endtask

	// edges on a pair in 64 cycles, after the pipe has settled
	task automatic togs_in(input bit ch, output int c);
		logic p;
		repeat (8) @(posedge pclk);
		c = 0;
		p = ch ? sa : fa;
		repeat (64) begin
			@(posedge pclk);
			if ((ch ? sa : fa) !== p) c++;
			p = ch ? sa : fa;
		end
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{dist_clk_in, osc_clk_in, ext_clk_in, chip_sync_n} = 4'h1;
		dist_source_sel = 2'h0;
		cnt_ff = 8'h00;
		fail_count = 0;
		compares = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rchk(11'h640, 8'h00);
		rchk(11'h644, 8'h80);
		rchk(11'h648, 8'h00);
		rchk(11'h658, 8'h00);
		rchk(11'h65c, 8'h00);
		rchk(11'h660, 8'h00);
		// unmapped, misaligned and read-only places all refuse
		apb(1'h0, 11'h64c, 8'h00);
		`CHK(err, 1'h1)
		apb(1'h1, 11'h641, 8'h55);
		`CHK(err, 1'h1)
		apb(1'h1, 11'h680, 8'h55);
		`CHK(err, 1'h1)
		togs_in(1'h0, n);
		`CHK(n, 32)
		apb(1'h1, 11'h65c, 8'h80);
		togs_in(1'h1, n);
		`CHK(n, 32)
		apb(1'h1, 11'h65c, 8'h00);
		apb(1'h1, 11'h644, 8'h00);
		// span lengths; skip a period so the new counts are in force
		for (int ch = 0; ch < 2; ch++) begin
			for (int i = 0; i < 3; i++) begin
				apb(1'h1, ch ? 11'h658 : 11'h640, spans[i]);
				till(ch, 1'h1, n);
				till(ch, 1'h0, n);
				till(ch, 1'h1, n);
				till(ch, 1'h0, hi);
				till(ch, 1'h1, lo);
				`CHK(hi, (spans[i][3:0] + 1) * 4)
				`CHK(lo, (spans[i][7:4] + 1) * 4)
			end
		end
		// sync held: start level, or the forced level when sync is ignored
		chip_sync_n <= 1'h0;
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, 11'h65c, ctl_v[i]);
			repeat (12) @(posedge pclk);
			`CHK(sa, ~i[0])
			rchk(11'h680, {4'h0, i[1], 1'h0, ~i[0], 1'h0});
		end
		// release aligned to the input clock, so only the offset differs
		for (int p = 0; p < 2; p++) begin
			chip_sync_n <= 1'h0;
			apb(1'h1, 11'h65c, p ? 8'h0f : 8'h00);
			apb(1'h1, 11'h658, 8'h00);
			repeat (8) @(posedge pclk);
			n = 0;
			while (cnt_ff[3:0] !== 4'h0 && n < 20) begin
				@(posedge pclk);
				n++;
			end
			if (n >= 20) begin
				fail_count++;
				wrap_up();
			end
			chip_sync_n <= 1'h1;
			till(1'h1, 1'h1, hi);
			if (p == 0) d0 = hi;
		end
		`CHK(hi - d0, 60)
		apb(1'h1, 11'h640, 8'h33);
		apb(1'h1, 11'h648, 8'h02);
		for (int s = 0; s < 4; s++) begin
			dist_source_sel <= s[1:0];
			togs_in(1'h0, n);
			`CHK(n, togs[s])
		end
		apb(1'h1, 11'h648, 8'h03);
		`CHK(fdcc, 1'h1)
		apb(1'h1, 11'h660, 8'hff);
		rchk(11'h660, 8'h03);
		`CHK(sdcc, 1'h1)
		// a second reset restores defaults mid-run
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rchk(11'h644, 8'h80);
		`CHK(fdcc, 1'h0)
		wrap_up();
	end
endmodule
